// >>> core/fsu_pkg.sv
package fsu_pkg;

  // ****************************************************
  // Status word field positions
  // ****************************************************
  localparam int FLAG_LSB     = 0;   // Six exception flags 5-0
  localparam int FLAG_MSB     = 5;
  localparam int INVALID_BIT    = 0;   // Invalid operation flag
  localparam int INEXACT_BIT    = 5;   // Inexact flag
  localparam int STK_FAULT_BIT  = 6;   // Stack fault flag
  localparam int ERR_SUM_BIT    = 7;   // Error summary
  localparam int COND_ZERO_BIT  = 8;
  localparam int COND_ONE_BIT   = 9;
  localparam int COND_TWO_BIT   = 10;
  localparam int TOP_LSB        = 11;  // Stack head pointer 13-11
  localparam int TOP_MSB        = 13;
  localparam int COND_THREE_BIT = 14;
  localparam int BUSY_BIT     = 15;  // Mirror of error summary

  // ****************************************************
  // Tag codes and reset values
  // ****************************************************
  localparam logic [1:0]  TAG_VALID   = 2'h0;
  localparam logic [1:0]  TAG_ZERO    = 2'h1;
  localparam logic [1:0]  TAG_SPECIAL = 2'h2;
  localparam logic [1:0]  TAG_EMPTY   = 2'h3;
  localparam logic [15:0] TAG_RESET   = 16'hffff;
  localparam logic [5:0]  FLAG_RESET  = 6'h00;
  localparam logic [2:0]  TOP_RESET   = 3'h0;
  localparam logic [14:0] EXP_ALL_ONES = 15'h7fff;

  // ****************************************************
  // Compare result codes
  // ****************************************************
  localparam logic [1:0] CMP_GT = 2'h0;
  localparam logic [1:0] CMP_LT = 2'h1;
  localparam logic [1:0] CMP_EQ = 2'h2;
  localparam logic [1:0] CMP_UN = 2'h3;

  // Instruction class as seen by the condition logic
  typedef enum logic [2:0] {
    OP_NONE,
    OP_REM,
    OP_CMP,
    OP_ROUND,
    OP_TRIG,
    OP_CLASSIFY,
    OP_UNDEF_CC
  } fsu_op_t;

endpackage : fsu_pkg

// >>> core/fsu_tag_classify.sv
`timescale 1ns/1ps
`default_nettype none
module fsu_tag_classify (
  // Extended value
  input  wire logic [79:0] value_i,
  // Tag code
  output logic      [1:0]  tag_o
);

  // ****************************************************
  // Classification
  // ****************************************************
  logic [14:0] exp_w;  // Biased exponent
  logic [63:0] sig_w;  // Significand with integer bit

  assign exp_w = value_i[78:64];
  assign sig_w = value_i[63:0];

  // Zero, special or valid finite
  always_comb begin
    if (exp_w == 15'h0000) begin
      // Zero or denormal
      tag_o = (sig_w == 64'h0) ? fsu_pkg::TAG_ZERO : fsu_pkg::TAG_SPECIAL;
    end else if (exp_w == fsu_pkg::EXP_ALL_ONES) begin
      // Infinity or NaN
      tag_o = fsu_pkg::TAG_SPECIAL;
    end else begin
      // Unnormal is unsupported
      tag_o = sig_w[63] ? fsu_pkg::TAG_VALID : fsu_pkg::TAG_SPECIAL;
    end
  end

endmodule : fsu_tag_classify
`default_nettype wire

// >>> core/fsu_status_tag.sv
`timescale 1ns/1ps
`default_nettype none
module fsu_status_tag (
  // Clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rstn_i,
  // Instruction completion
  input  wire logic            op_done_i,
  input  wire fsu_pkg::fsu_op_t op_class_i,
  input  wire logic [5:0]      exc_i,
  input  wire logic            stack_fault_i,
  input  wire logic            stack_ovf_i,
  input  wire logic            rem_incomplete_i,
  input  wire logic [2:0]      quotient_i,
  input  wire logic [1:0]      cmp_result_i,
  input  wire logic            roundup_i,
  input  wire logic            trig_too_large_i,
  input  wire logic [3:0]      class_cc_i,
  input  wire logic            clear_exc_i,
  // Control word masks
  input  wire logic [5:0]      ctrl_mask_i,
  // Register stack traffic
  input  wire logic            push_i,
  input  wire logic            pop_i,
  input  wire logic            wr_i,
  input  wire logic [2:0]      wr_idx_i,
  input  wire logic [79:0]     wr_value_i,
  // State reload
  input  wire logic            load_env_op_i,
  input  wire logic            restore_all_op_i,
  input  wire logic [15:0]     status_load_i,
  input  wire logic [15:0]     tag_load_i,
  // Visible state
  output logic      [15:0]     numeric_status_word_o,
  output logic      [15:0]     register_class_word_o,
  output logic                 error_o,
  output logic      [2:0]      stack_head_o
);

  // ****************************************************
  // State
  // ****************************************************
  logic [5:0]  exc_flag;        // Sticky exception flags
  logic        stack_fault_flag;
  logic        error_summary;
  logic        cond_bit_zero;
  logic        cond_bit_one;
  logic        cond_bit_two;
  logic        cond_bit_three;
  logic [2:0]  top;             // Stack head pointer
  logic [15:0] tag_word;        // Absolute tag fields
  logic        error_q;         // Error pin flop

  logic [5:0]  next_exc_flag;
  logic        next_stack_fault_flag;
  logic        next_error_summary;
  logic        next_cond_bit_zero;
  logic        next_cond_bit_one;
  logic        next_cond_bit_two;
  logic        next_cond_bit_three;
  logic [2:0]  next_top;
  logic [15:0] next_tag_word;

  logic [1:0]  wr_tag;          // Class of written value
  logic        reload;          // Either reload operation
  logic        wr_allowed;      // Write not suppressed
  logic        stack_exc_now;   // Invalid and stack fault flags both set after this op

  // Error summary from flags and masks
  function automatic logic calc_es(input logic [5:0] flags, input logic [5:0] masks);
    calc_es = |(flags & ~masks);
  endfunction : calc_es

  // ****************************************************
  // Tag classification of written data
  // ****************************************************
  fsu_tag_classify u_classify (
    .value_i (wr_value_i),
    .tag_o   (wr_tag)
  );

  assign reload        = load_env_op_i | restore_all_op_i;
  assign stack_exc_now = next_exc_flag[fsu_pkg::INVALID_BIT] & next_stack_fault_flag;

  // Too large trig operand stays at the head untouched
  assign wr_allowed = wr_i & ~(op_done_i & (op_class_i == fsu_pkg::OP_TRIG)
                               & trig_too_large_i);

  // ****************************************************
  // Exception flags and error summary
  // ****************************************************
  always_comb begin
    next_exc_flag         = exc_flag;
    next_stack_fault_flag = stack_fault_flag;
    if (reload) begin
      // Flags come from the memory image
      next_exc_flag         = status_load_i[fsu_pkg::FLAG_MSB:fsu_pkg::FLAG_LSB];
      next_stack_fault_flag = status_load_i[fsu_pkg::STK_FAULT_BIT];
    end else begin
      // Clear first, new event wins over it
      if (clear_exc_i) begin
        next_exc_flag         = fsu_pkg::FLAG_RESET;
        next_stack_fault_flag = 1'b0;
      end
      if (op_done_i) begin
        next_exc_flag         = next_exc_flag | exc_i;
        next_stack_fault_flag = next_stack_fault_flag | stack_fault_i;
      end
    end
    // Memory value of bit 7 and bit 15 is ignored
    next_error_summary = calc_es(next_exc_flag, ctrl_mask_i);
  end

  // ****************************************************
  // Condition bits
  // ****************************************************
  always_comb begin
    next_cond_bit_zero  = cond_bit_zero;
    next_cond_bit_one   = cond_bit_one;
    next_cond_bit_two   = cond_bit_two;
    next_cond_bit_three = cond_bit_three;
    if (reload) begin
      // Each bit loaded from memory
      next_cond_bit_zero  = status_load_i[fsu_pkg::COND_ZERO_BIT];
      next_cond_bit_one   = status_load_i[fsu_pkg::COND_ONE_BIT];
      next_cond_bit_two   = status_load_i[fsu_pkg::COND_TWO_BIT];
      next_cond_bit_three = status_load_i[fsu_pkg::COND_THREE_BIT];
    end else if (op_done_i) begin
      unique case (op_class_i)
        fsu_pkg::OP_REM: begin
          // Reduction state in bit two
          next_cond_bit_two = rem_incomplete_i;
          if (!rem_incomplete_i) begin
            // Quotient modulo 8
            next_cond_bit_zero  = quotient_i[2];
            next_cond_bit_three = quotient_i[1];
            next_cond_bit_one   = quotient_i[0];
          end
          if (stack_exc_now) begin
            // Stack fault direction wins over the quotient bit
            next_cond_bit_one = stack_ovf_i;
          end
        end
        fsu_pkg::OP_CMP: begin
          // Order result in bits 3, 2, 0
          next_cond_bit_three = (cmp_result_i == fsu_pkg::CMP_EQ) |
                                (cmp_result_i == fsu_pkg::CMP_UN);
          next_cond_bit_two   = (cmp_result_i == fsu_pkg::CMP_UN);
          next_cond_bit_zero  = (cmp_result_i == fsu_pkg::CMP_LT) |
                                (cmp_result_i == fsu_pkg::CMP_UN);
          next_cond_bit_one   = stack_exc_now ? stack_ovf_i : 1'b0;
        end
        fsu_pkg::OP_ROUND: begin
          // Round-up report only when inexact
          if (stack_exc_now) begin
            next_cond_bit_one = stack_ovf_i;
          end else begin
            next_cond_bit_one = next_exc_flag[fsu_pkg::INEXACT_BIT] & roundup_i;
          end
        end
        fsu_pkg::OP_TRIG: begin
          // Too large operand flagged in bit two
          next_cond_bit_two = trig_too_large_i;
          if (stack_exc_now) begin
            next_cond_bit_one = stack_ovf_i;
          end else if (!trig_too_large_i) begin
            next_cond_bit_one = next_exc_flag[fsu_pkg::INEXACT_BIT] & roundup_i;
          end
        end
        fsu_pkg::OP_CLASSIFY: begin
          // Operand class code, bit one is sign
          next_cond_bit_three = class_cc_i[3];
          next_cond_bit_two   = class_cc_i[2];
          next_cond_bit_one   = stack_exc_now ? stack_ovf_i : class_cc_i[1];
          next_cond_bit_zero  = class_cc_i[0];
        end
        fsu_pkg::OP_UNDEF_CC: begin
          // Undefined bits keep their value
          if (stack_exc_now) begin
            next_cond_bit_one = stack_ovf_i;
          end
        end
        fsu_pkg::OP_NONE: begin
          // Only the stack fault direction can change
          if (stack_exc_now) begin
            next_cond_bit_one = stack_ovf_i;
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Stack head and tag word
  // ****************************************************
  always_comb begin
    next_top      = top;
    next_tag_word = tag_word;
    if (reload) begin
      // Pointer and tags from the memory image
      next_top      = status_load_i[fsu_pkg::TOP_MSB:fsu_pkg::TOP_LSB];
      next_tag_word = tag_load_i;
    end else begin
      if (pop_i) begin
        // Old head becomes empty
        next_tag_word[{top, 1'b0} +: 2] = fsu_pkg::TAG_EMPTY;
        next_top = top + 3'h1;
      end else if (push_i) begin
        next_top = top - 3'h1;
      end
      if (wr_allowed) begin
        // Written register, incl. partial remainder at head
        next_tag_word[{wr_idx_i, 1'b0} +: 2] = wr_tag;
      end
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      exc_flag         <= fsu_pkg::FLAG_RESET;
      stack_fault_flag <= 1'b0;
      error_summary    <= 1'b0;
      cond_bit_zero    <= 1'b0;
      cond_bit_one     <= 1'b0;
      cond_bit_two     <= 1'b0;
      cond_bit_three   <= 1'b0;
      top              <= fsu_pkg::TOP_RESET;
      tag_word         <= fsu_pkg::TAG_RESET;
      error_q          <= 1'b0;
    end else begin
      exc_flag         <= next_exc_flag;
      stack_fault_flag <= next_stack_fault_flag;
      error_summary    <= next_error_summary;
      cond_bit_zero    <= next_cond_bit_zero;
      cond_bit_one     <= next_cond_bit_one;
      cond_bit_two     <= next_cond_bit_two;
      cond_bit_three   <= next_cond_bit_three;
      top              <= next_top;
      tag_word         <= next_tag_word;
      // Error follows summary in the same edge, reload included
      error_q          <= next_error_summary;
    end
  end

  // ****************************************************
  // Outputs, all flop bits
  // ****************************************************
  assign numeric_status_word_o = {error_summary,
                                  cond_bit_three,
                                  top,
                                  cond_bit_two,
                                  cond_bit_one,
                                  cond_bit_zero,
                                  error_summary,
                                  stack_fault_flag,
                                  exc_flag};
  assign register_class_word_o = tag_word;
  assign error_o               = error_q;
  assign stack_head_o          = top;

endmodule : fsu_status_tag
`default_nettype wire

// >>> bench/fsu_status_tag_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fsu_status_tag_sva (
  // Block inputs
  input wire logic             core_clk_i,
  input wire logic             rstn_i,
  input wire logic             op_done_i,
  input wire fsu_pkg::fsu_op_t op_class_i,
  input wire logic [5:0]       exc_i,
  input wire logic             stack_fault_i,
  input wire logic             stack_ovf_i,
  input wire logic             rem_incomplete_i,
  input wire logic [2:0]       quotient_i,
  input wire logic [1:0]       cmp_result_i,
  input wire logic             roundup_i,
  input wire logic             trig_too_large_i,
  input wire logic             clear_exc_i,
  input wire logic [5:0]       ctrl_mask_i,
  input wire logic             load_env_op_i,
  input wire logic             restore_all_op_i,
  input wire logic [15:0]      status_load_i,
  // Block outputs
  input wire logic [15:0]      numeric_status_word_o,
  input wire logic             error_o
);
  // Compare code to condition bits three, two, zero
  localparam logic [2:0] CMP_TAB [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
  wire logic [15:0] s  = numeric_status_word_o;
  wire logic        ld = load_env_op_i | restore_all_op_i;
  wire logic        op = op_done_i & ~ld;
  wire logic        ok = ~stack_fault_i & ~s[6];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_err; error_o == s[7] && s[15] == s[7]; endproperty
  a_err: assert property (p_err) else $error("error out or busy bit off");
  property p_es; $past(rstn_i) |-> s[7] == |(s[5:0] & ~$past(ctrl_mask_i)); endproperty
  a_es: assert property (p_es) else $error("summary bit wrong");
  property p_load; ld |=> (s & 16'h7f7f) == ($past(status_load_i) & 16'h7f7f); endproperty
  a_load: assert property (p_load) else $error("reload image wrong");
  property p_cmp; op && op_class_i == fsu_pkg::OP_CMP && ok |=> !s[9] &&
    {s[14], s[10], s[8]} == CMP_TAB[$past(cmp_result_i)]; endproperty
  a_cmp: assert property (p_cmp) else $error("compare code wrong");
  property p_rem; op && op_class_i == fsu_pkg::OP_REM && ok |=> s[10] == $past(rem_incomplete_i)
    && (s[10] || {s[8], s[14], s[9]} == $past(quotient_i)); endproperty
  a_rem: assert property (p_rem) else $error("remainder code wrong");
  property p_ovf; op && stack_fault_i && exc_i[0] |=> s[9] == $past(stack_ovf_i) && s[6]; endproperty
  a_ovf: assert property (p_ovf) else $error("stack direction wrong");
  property p_rnd; op && op_class_i == fsu_pkg::OP_ROUND && exc_i[5] && ok |=> s[9] == $past(roundup_i);
  endproperty
  a_rnd: assert property (p_rnd) else $error("roundup bit wrong");
  property p_trig; op && op_class_i == fsu_pkg::OP_TRIG && trig_too_large_i |=> s[10]; endproperty
  a_trig: assert property (p_trig) else $error("trig range bit wrong");
  property p_stick; op && !clear_exc_i |=> (s & 16'h3f) == (($past(s) | {10'h0, $past(exc_i)}) & 16'h3f);
  endproperty
  a_stick: assert property (p_stick) else $error("flags not sticky");
  c_load: cover property (ld ##1 error_o);
  c_unord: cover property (op && op_class_i == fsu_pkg::OP_CMP && cmp_result_i == 2'h3);
  c_rem: cover property (op && op_class_i == fsu_pkg::OP_REM && rem_incomplete_i);
endmodule : fsu_status_tag_sva
bind fsu_status_tag fsu_status_tag_sva u_sva (.*);
`default_nettype wire

// >>> bench/fsu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsu_host_model (
  // Clock
  input  wire logic             core_clk_i,
  // Requests toward the block
  output var logic              op_done_i,
  output var fsu_pkg::fsu_op_t  op_class_i,
  output var logic [5:0]        exc_i,
  output var logic              stack_fault_i,
  output var logic              stack_ovf_i,
  output var logic              rem_incomplete_i,
  output var logic [2:0]        quotient_i,
  output var logic [1:0]        cmp_result_i,
  output var logic              roundup_i,
  output var logic              trig_too_large_i,
  output var logic [3:0]        class_cc_i,
  output var logic              clear_exc_i,
  output var logic [5:0]        ctrl_mask_i,
  output var logic              push_i,
  output var logic              pop_i,
  output var logic              wr_i,
  output var logic [2:0]        wr_idx_i,
  output var logic [79:0]       wr_value_i,
  output var logic              load_env_op_i,
  output var logic              restore_all_op_i,
  output var logic [15:0]       status_load_i,
  output var logic [15:0]       tag_load_i
);
  // Idle, every exception masked
  initial begin
    op_class_i = fsu_pkg::OP_NONE;
    {op_done_i, exc_i, stack_fault_i, stack_ovf_i, class_cc_i, clear_exc_i, rem_incomplete_i,
     quotient_i, cmp_result_i, roundup_i, trig_too_large_i} = '0;
    {push_i, pop_i, wr_i, wr_idx_i, wr_value_i, load_env_op_i, restore_all_op_i} = '0;
    {status_load_i, tag_load_i, ctrl_mask_i} = {32'h0, 6'h3f};
  end
  // One instruction ends; f is {fault, overflow}, a the class result
  task automatic issue(input fsu_pkg::fsu_op_t c, input logic [5:0] e, input logic [1:0] f,
                       input logic [3:0] a);
    @(negedge core_clk_i);
    {op_done_i, exc_i, stack_fault_i, stack_ovf_i, class_cc_i} = {1'b1, e, f, a};
    {rem_incomplete_i, quotient_i} = a;
    {trig_too_large_i, roundup_i} = a[1:0];
    cmp_result_i = a[1:0];
    op_class_i = c;
    @(negedge core_clk_i);
    op_done_i = 1'b0;
  endtask : issue
  // Too large trig operand with a register write in the same cycle
  task automatic trig_wr(input logic [2:0] i, input logic [79:0] v);
    @(negedge core_clk_i);
    {op_done_i, exc_i, stack_fault_i, trig_too_large_i, wr_i} = {1'b1, 6'h0, 3'h3};
    {wr_idx_i, wr_value_i} = {i, v};
    op_class_i = fsu_pkg::OP_TRIG;
    @(negedge core_clk_i);
    {op_done_i, wr_i} = 2'h0;
  endtask : trig_wr
  // State reload from a memory image
  task automatic reload(input logic env, input logic [15:0] st, input logic [15:0] tg);
    @(negedge core_clk_i);
    {load_env_op_i, restore_all_op_i, status_load_i, tag_load_i} = {env, !env, st, tg};
    @(negedge core_clk_i);
    {load_env_op_i, restore_all_op_i} = 2'h0;
  endtask : reload
  // k is {push, pop, clear, write}
  task automatic misc(input logic [3:0] k, input logic [2:0] i, input logic [79:0] v);
    @(negedge core_clk_i);
    {push_i, pop_i, clear_exc_i, wr_i, wr_idx_i, wr_value_i} = {k, i, v};
    @(negedge core_clk_i);
    {push_i, pop_i, clear_exc_i, wr_i} = 4'h0;
  endtask : misc
  // New masks, one edge to settle
  task automatic mask(input logic [5:0] m);
    @(negedge core_clk_i);
    ctrl_mask_i = m;
    @(negedge core_clk_i);
  endtask : mask
endmodule : fsu_host_model
`default_nettype wire

// >>> bench/fsu_status_tag_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsu_status_tag_tb;
  logic             core_clk_i = 1'b0;
  logic             rstn_i     = 1'b0;
  wire logic        op_done_i, stack_fault_i, stack_ovf_i, rem_incomplete_i, roundup_i;
  wire logic        trig_too_large_i, clear_exc_i, push_i, pop_i, wr_i, error_o;
  wire logic        load_env_op_i, restore_all_op_i;
  wire logic [1:0]  cmp_result_i;
  wire logic [2:0]  quotient_i, wr_idx_i, stack_head_o;
  wire logic [3:0]  class_cc_i;
  wire logic [5:0]  exc_i, ctrl_mask_i;
  wire logic [15:0] status_load_i, tag_load_i, numeric_status_word_o, register_class_word_o;
  wire logic [79:0] wr_value_i;
  wire fsu_pkg::fsu_op_t op_class_i;
  wire logic [15:0] st = numeric_status_word_o;
  wire logic [15:0] tg = register_class_word_o;
  wire logic [3:0]  cc = {st[14], st[10], st[9], st[8]};
  logic [3:0]       cmp_tab [4] = '{4'h0, 4'h1, 4'h8, 4'hd};
  int               miscompares = 0;
  int               comparisons = 0;
  fsu_status_tag u_dut (.*);
  fsu_host_model u_host (.*);
  always #10 core_clk_i = ~core_clk_i;
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // Hang guard
  initial begin
    repeat (2000) @(posedge core_clk_i);
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk("status", st, 16'h0000);
    chk("tags", tg, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      u_host.issue(fsu_pkg::OP_CMP, 6'h0, 2'h0, 4'(i));
      chk("cmp", {12'h0, cc}, {12'h0, cmp_tab[i]});
    end
    for (int i = 0; i < 9; i++) begin
      u_host.issue(fsu_pkg::OP_REM, 6'h0, 2'h0, 4'(i));
      if (i == 8) begin
        chk("rem_part", {12'h0, cc & 4'h4}, 16'h0004);
      end else begin
        chk("rem", {12'h0, cc}, {12'h0, i[1], 1'b0, i[0], i[2]});
      end
    end
    u_host.issue(fsu_pkg::OP_CLASSIFY, 6'h0, 2'h0, 4'hb);
    chk("class", {12'h0, cc}, 16'hb);
    u_host.issue(fsu_pkg::OP_TRIG, 6'h0, 2'h0, 4'h2);
    chk("trig", {15'h0, st[10]}, 16'h1);
    u_host.issue(fsu_pkg::OP_ROUND, 6'h20, 2'h0, 4'h1);
    chk("round", st & 16'h82bf, 16'h0220);
    u_host.mask(6'h1f);
    chk("unmask", st & 16'h80bf, 16'h80a0);
    u_host.issue(fsu_pkg::OP_UNDEF_CC, 6'h04, 2'h0, 4'h0); // Codes not read
    chk("sticky", st & 16'h3f, 16'h24);
    u_host.issue(fsu_pkg::OP_NONE, 6'h01, 2'h3, 4'h0);
    chk("ovf", st & 16'h0241, 16'h0241);
    u_host.issue(fsu_pkg::OP_NONE, 6'h01, 2'h2, 4'h0);
    chk("unf", st & 16'h0241, 16'h0041);
    u_host.misc(4'h2, 3'h0, 80'h0);
    chk("clear", st & 16'h80ff, 16'h0);
    u_host.mask(6'h3e);
    u_host.reload(1'b1, 16'h6d01, 16'h1234);
    chk("env", st, 16'hed81);
    chk("envtag", tg, 16'h1234);
    chk("error", {15'h0, error_o}, 16'h1);
    chk("head", {13'h0, stack_head_o}, 16'h5);
    u_host.mask(6'h01);
    u_host.reload(1'b0, 16'h8081, 16'h0000);
    chk("restore", st, 16'h0001);
    u_host.misc(4'h1, 3'h3, 80'h0);
    chk("zero", tg, 16'h0040);
    u_host.misc(4'h1, 3'h6, {1'b0, 15'h7fff, 64'h8000_0000_0000_0000});
    chk("inf", tg, 16'h2040);
    u_host.misc(4'h4, 3'h0, 80'h0);
    chk("pop", tg, 16'h2043);
    chk("pophead", {13'h0, stack_head_o}, 16'h1);
    u_host.misc(4'h1, 3'h0, 80'h3fff_8000_0000_0000_0000);
    chk("valid", tg, 16'h2040);
    u_host.trig_wr(3'h0, 80'h0);
    chk("trigkeep", tg, 16'h2040);
    chk("trigbit", {15'h0, st[10]}, 16'h1);
    end_sim();
  end
endmodule : fsu_status_tag_tb
`default_nettype wire
